// *** include/sadc_pkg.sv ***
package sadc_pkg;
   // Register byte addresses on the bus
   localparam logic [4:0] A_SCR = 5'h00;
   localparam logic [4:0] A_RH = 5'h04;
   localparam logic [4:0] A_RL = 5'h08;
   localparam logic [4:0] A_CLK = 5'h0C;
   localparam logic [4:0] A_PDAT = 5'h10;
   localparam logic [4:0] A_PDIR = 5'h14;
   // Status/control fields
   localparam int SCR_FLAG = 7;
   localparam int SCR_IEN = 6;
   localparam int SCR_CONT = 5;
   // Clock register fields
   localparam int CLK_DIV_HI = 7;
   localparam int CLK_DIV_LO = 5;
   localparam int CLK_SRC = 4;
   localparam int FMT_HI = 3;
   localparam int FMT_LO = 2;
   // Reset values and codes
   localparam logic [4:0] CH_OFF = 5'h1F;
   localparam logic [7:0] CLK_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h00;
   // Conversion phases, counted in converter clock ticks
   localparam logic [4:0] PH_TRIAL_FIRST = 5'h01;
   localparam logic [4:0] PH_TRIAL_LAST = 5'h0A;
   localparam logic [4:0] PH_LAST = 5'h10;
   localparam logic [9:0] SAR_MID = 10'h200;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SETTLE = 3'b010,
      ST_CONV = 3'b100
   } sadc_st_t;
   typedef enum logic [1:0] {
      FMT_TRUNC = 2'h0,
      FMT_RIGHT = 2'h1,
      FMT_LEFT = 2'h2,
      FMT_SIGNED = 2'h3
   } sadc_fmt_t;
   // Toward the analog mux and comparator DAC
   typedef struct packed {
      logic pwr;
      logic sample;
      logic [4:0] chan;
      logic [9:0] code;
   } sadc_ana_t;
   typedef struct packed {
      sadc_st_t st;
      logic [4:0] ph;
      logic [4:0] chan;
      logic cont;
      logic ien;
      logic flag;
      logic irq;
      logic [7:0] clkr;
      logic [7:0] rh;
      logic [7:0] rl;
      logic lock;
      logic run;
      logic settle;
      logic [7:0] pdat;
      logic [7:0] pdir;
      logic [7:0] poe;
      logic pwr;
      logic sample;
      logic wreq;
      logic [7:0] rdat;
   } sadc_top_st_t;
   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } sadc_div_st_t;
   typedef struct packed {
      logic [9:0] code;
      logic [9:0] mask;
   } sadc_sar_st_t;
endpackage

// *** rtl/sadc_clkdiv.sv ***
`timescale 1ns/1ps
`default_nettype none
module sadc_clkdiv
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic base_en_i,
   input wire logic [2:0] div_i,
   output logic tick_o
);
   import sadc_pkg::*;
   sadc_div_st_t s_r, s_nxt;
   logic [3:0] lim;
   // Divide ratio 1, 2, 4, 8 or 16
   always_comb
   begin
      lim = div_i[2] ? 4'hF : 4'((4'h1 << div_i[1:0]) - 4'h1);
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (base_en_i)
      begin
         s_nxt.tick = ((s_r.cnt & lim) == lim);
         s_nxt.cnt = s_nxt.tick ? 4'h0 : 4'(s_r.cnt + 4'h1);
      end
   end
   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign tick_o = s_r.tick;
endmodule
`default_nettype wire

// *** rtl/sadc_sar.sv ***
`timescale 1ns/1ps
`default_nettype none
module sadc_sar
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic step_i,
   input wire logic cmp_i,
   output logic [9:0] code_o
);
   import sadc_pkg::*;
   sadc_sar_st_t s_r, s_nxt;
   // Binary search, one bit per trial, high bit first
   always_comb
   begin
      s_nxt = s_r;
      if (start_i)
      begin
         s_nxt.code = SAR_MID;
         s_nxt.mask = SAR_MID;
      end
      else if (step_i && s_r.mask != 10'h000)
      begin
         // Keep the trial bit when input is at or above the DAC level
         s_nxt.code = (cmp_i ? s_r.code : (s_r.code & ~s_r.mask)) | (s_r.mask >> 1);
         s_nxt.mask = s_r.mask >> 1;
      end
   end
   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
   assign code_o = s_r.code;
   property p_trial_walk;
      @(posedge clk_i) disable iff (rst_i)
      (step_i && !start_i && s_r.mask != 10'h000) |=> (s_r.mask == ($past(s_r.mask) >> 1));
   endproperty
   a_trial_walk: assert property (p_trial_walk) else $error("trial mask did not advance");
endmodule
`default_nettype wire

// *** rtl/sadc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - selected channel pin becomes converter input
// - selected pin ignores port writes, reads zero
// - upper reference gives 3FF, lower gives 000
// - conversion ends 16 to 17 converter clocks
// - continuous mode overwrites results until cleared
// - flag set each stored conversion with irq disabled, cleared by result read
// - single mode converts once per control write
// - four result formats from format field
// - left format, high read locks new results
// - right format, two high, eight low
// - signed format inverts the top bit
// - truncation puts top eight in low, unlocked
// - interrupt enabled raises irq, flag reads zero
// - converter runs in wait, irq wakes
// - stop aborts; first period after stabilizes
// - five-bit channel field, codes 0-7 external
// - all-ones channel code powers converter off
// - irq cleared by result read or control write
// - high read freezes low until low read
module sadc_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [7:0] port_pin_i,
   output logic [7:0] port_pin_o,
   output logic [7:0] port_pin_oe_o,
   input wire logic cmp_i,
   input wire logic alt_tick_i,
   input wire logic stop_i,
   output sadc_pkg::sadc_ana_t ana_o,
   output logic irq_o
);
   import sadc_pkg::*;
   sadc_top_st_t s, n;
   logic tick;
   logic [9:0] code;
   logic [7:0] use_mask;
   logic [7:0] wdat;
   logic commit_rd, commit_wr;
   logic scr_wr, rh_rd, rl_rd, res_rd;
   logic [4:0] new_chan;
   logic powered;
   logic done_w, conv_start, sar_step;
   sadc_fmt_t fmt;

   // Bus handshake terms; a request completes when waitrequest is low
   assign commit_rd = avs_read_i && !s.wreq;
   assign commit_wr = avs_write_i && !s.wreq && avs_byteenable_i[0];
   assign wdat = avs_writedata_i[7:0];
   assign scr_wr = commit_wr && avs_address_i == A_SCR;
   assign rh_rd = commit_rd && avs_address_i == A_RH;
   assign rl_rd = commit_rd && avs_address_i == A_RL;
   assign res_rd = rh_rd || rl_rd;
   assign new_chan = scr_wr ? wdat[4:0] : s.chan;
   assign powered = new_chan != CH_OFF;
   assign fmt = sadc_fmt_t'(s.clkr[FMT_HI:FMT_LO]);
   assign done_w = s.st == ST_CONV && tick && s.ph == PH_LAST;
   assign sar_step = s.st == ST_CONV && tick && s.ph >= PH_TRIAL_FIRST
                     && s.ph <= PH_TRIAL_LAST;

   // One pin per external channel code 0 to 7
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_use
         assign use_mask[g] = (s.chan == 5'(g));
      end
   endgenerate

   // Converter clock enable
   sadc_clkdiv u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .base_en_i(s.clkr[CLK_SRC] ? alt_tick_i : 1'b1),
      .div_i(s.clkr[CLK_DIV_HI:CLK_DIV_LO]),
      .tick_o(tick)
   );

   // Successive approximation engine
   sadc_sar u_sar (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(conv_start),
      .step_i(sar_step),
      .cmp_i(cmp_i),
      .code_o(code)
   );

   // Next state: bus, registers, pins and conversion sequencer
   always_comb
   begin
      n = s;
      conv_start = 1'b0;
      n.wreq = !((avs_read_i || avs_write_i) && s.wreq);
      if ((avs_read_i || avs_write_i) && s.wreq)
      begin
         case (avs_address_i)
            A_SCR: n.rdat = {s.flag && !s.ien, s.ien, s.cont, s.chan};
            A_RH: n.rdat = s.rh;
            A_RL: n.rdat = s.rl;
            A_CLK: n.rdat = s.clkr;
            A_PDAT: n.rdat = ((s.pdir & s.pdat) | (~s.pdir & port_pin_i))
                             & ~use_mask;
            A_PDIR: n.rdat = s.pdir & ~use_mask;
            default: n.rdat = 8'h00;
         endcase
      end
      // Register writes
      if (scr_wr)
      begin
         n.ien = wdat[SCR_IEN];
         n.cont = wdat[SCR_CONT];
         n.chan = wdat[4:0];
         n.irq = 1'b0;
         n.run = 1'b1;
      end
      if (commit_wr && avs_address_i == A_CLK)
         n.clkr = wdat;
      if (commit_wr && avs_address_i == A_PDAT)
         n.pdat = (s.pdat & use_mask) | (wdat & ~use_mask);
      if (commit_wr && avs_address_i == A_PDIR)
         n.pdir = (s.pdir & use_mask) | (wdat & ~use_mask);
      // Pin in use by the converter is not driven, from one cycle after it is selected
      n.poe = s.pdir & ~use_mask;
      // Result reads clear the event and move the interlock
      if (res_rd)
      begin
         n.flag = 1'b0;
         n.irq = 1'b0;
      end
      if (rh_rd && fmt != FMT_TRUNC)
         n.lock = 1'b1;
      if (rl_rd)
         n.lock = 1'b0;
      // Sequencer
      case (s.st)
         ST_IDLE:
         begin
            n.ph = 5'h00;
         end
         ST_SETTLE:
         begin
            if (tick)
               n.ph = 5'(s.ph + 5'h01);
            if (tick && s.ph == PH_LAST)
            begin
               n.st = ST_CONV;
               n.ph = 5'h00;
               n.settle = 1'b0;
               conv_start = 1'b1;
            end
         end
         ST_CONV:
         begin
            if (tick)
               n.ph = 5'(s.ph + 5'h01);
            if (done_w)
            begin
               n.st = ST_IDLE;
               n.ph = 5'h00;
               n.run = scr_wr || s.cont;
               // Held results drop new ones, except in truncation
               if (fmt == FMT_TRUNC || !s.lock)
               begin
                  case (fmt)
                     FMT_TRUNC:
                     begin
                        n.rh = 8'h00;
                        n.rl = code[9:2];
                     end
                     FMT_RIGHT:
                     begin
                        n.rh = {6'h00, code[9:8]};
                        n.rl = code[7:0];
                     end
                     FMT_LEFT:
                     begin
                        n.rh = code[9:2];
                        n.rl = {code[1:0], 6'h00};
                     end
                     FMT_SIGNED:
                     begin
                        n.rh = {~code[9], code[8:2]};
                        n.rl = {code[1:0], 6'h00};
                     end
                     default:
                     begin
                        n.rh = 8'h00;
                        n.rl = 8'h00;
                     end
                  endcase
                  // Set wins over a clear in the same cycle
                  if (s.ien)
                     n.irq = 1'b1;
                  else
                     n.flag = 1'b1;
               end
            end
         end
         default:
         begin
            n.st = ST_IDLE;
            n.ph = 5'h00;
         end
      endcase
      // Power off and stop abort; control write or continuous restarts
      if (!powered || stop_i)
      begin
         n.st = ST_IDLE;
         n.ph = 5'h00;
         n.settle = 1'b1;
      end
      else if (scr_wr || (s.st == ST_IDLE && s.run) || (done_w && s.cont))
      begin
         n.ph = 5'h00;
         n.st = s.settle ? ST_SETTLE : ST_CONV;
         conv_start = !s.settle;
      end
      n.pwr = powered && !stop_i;
      n.sample = n.st == ST_CONV && n.ph == 5'h00;
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s <= '0;
         s.st <= ST_IDLE;
         s.chan <= CH_OFF;
         s.clkr <= CLK_RST;
         s.pdat <= PORT_RST;
         s.pdir <= PORT_RST;
         s.poe <= PORT_RST;
         s.settle <= 1'b1;
         s.wreq <= 1'b1;
      end
      else
         s <= n;
   end

   // Outputs straight from registers
   assign avs_readdata_o = {24'h000000, s.rdat};
   assign avs_waitrequest_o = s.wreq;
   assign port_pin_o = s.pdat;
   assign port_pin_oe_o = s.poe;
   assign irq_o = s.irq;
   assign ana_o = '{pwr: s.pwr, sample: s.sample, chan: s.chan, code: code};

   // Cycle count from conversion start, for timing checks
   logic [5:0] a_cyc;
   logic a_fast;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         a_cyc <= 6'h00;
         a_fast <= 1'b0;
      end
      else if (conv_start)
      begin
         a_cyc <= 6'h00;
         a_fast <= s.clkr[CLK_DIV_HI:CLK_SRC] == 4'h0 && tick;
      end
      else
      begin
         a_cyc <= (a_cyc == 6'h3F) ? a_cyc : 6'(a_cyc + 6'h01);
         if (!tick || s.clkr[CLK_DIV_HI:CLK_SRC] != 4'h0)
            a_fast <= 1'b0;
      end
   end

   sequence s_no_ctl;
      !scr_wr && !stop_i;
   endsequence
   sequence s_idle_hold;
      (s.st == ST_IDLE || s.run)[*4];
   endsequence

   property p_pin_taken;
      @(posedge clk_i) disable iff (rst_i)
      (s.chan < 5'h08 && $stable(s.chan)) |-> !port_pin_oe_o[s.chan[2:0]];
   endproperty
   a_pin_taken: assert property (p_pin_taken) else $error("selected pin still driven");

   property p_pin_reads_zero;
      @(posedge clk_i) disable iff (rst_i)
      (commit_rd && avs_address_i == A_PDAT && s.chan < 5'h08 && $stable(s.chan))
      |-> avs_readdata_o[s.chan[2:0]] == 1'b0;
   endproperty
   a_pin_reads_zero: assert property (p_pin_reads_zero) else $error("selected pin read not 0");

   property p_conv_time;
      @(posedge clk_i) disable iff (rst_i)
      (done_w && a_fast) |-> a_cyc == 6'h10;
   endproperty
   a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

   property p_cont_restart;
      @(posedge clk_i) disable iff (rst_i)
      ((done_w && s.cont && powered && !s.settle) and s_no_ctl)
      |=> (s.st == ST_CONV && s.ph == 5'h00);
   endproperty
   a_cont_restart: assert property (p_cont_restart) else $error("continuous did not restart");

   property p_flag_hold;
      @(posedge clk_i) disable iff (rst_i)
      (s.flag && !res_rd) |=> s.flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");

   property p_single_once;
      @(posedge clk_i) disable iff (rst_i)
      (done_w && !s.cont && !scr_wr) ##1 (!scr_wr)[*3] |=> s_idle_hold;
   endproperty
   a_single_once: assert property (p_single_once) else $error("single mode converted again");

   property p_trunc;
      @(posedge clk_i) disable iff (rst_i)
      (done_w && fmt == FMT_TRUNC) |=> (s.rh == 8'h00 && s.rl == $past(code[9:2]));
   endproperty
   a_trunc: assert property (p_trunc) else $error("truncation layout wrong");

   property p_irq_event;
      @(posedge clk_i) disable iff (rst_i)
      (done_w && s.ien && !s.lock) |=> (irq_o && (!s.flag || $past(s.flag)));
   endproperty
   a_irq_event: assert property (p_irq_event) else $error("irq not raised");

   property p_irq_clear;
      @(posedge clk_i) disable iff (rst_i)
      ((res_rd || scr_wr) && !done_w) |=> !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");

   property p_lock;
      @(posedge clk_i) disable iff (rst_i)
      (s.lock && !rl_rd && fmt != FMT_TRUNC) |=> $stable(s.rl);
   endproperty
   a_lock: assert property (p_lock) else $error("low result changed while locked");

   property p_stop;
      @(posedge clk_i) disable iff (rst_i)
      stop_i |=> (s.st == ST_IDLE && s.settle && !ana_o.pwr);
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not abort");

   property p_off;
      @(posedge clk_i) disable iff (rst_i)
      (s.chan == CH_OFF && !scr_wr) |=> (s.st == ST_IDLE && !ana_o.pwr);
   endproperty
   a_off: assert property (p_off) else $error("converter not powered off");
endmodule
`default_nettype wire

// *** tb/sadc_ana_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Mux plus ideal comparator facing the converter
module sadc_ana_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire sadc_pkg::sadc_ana_t ana_i,
   input wire logic [7:0][9:0] lvl_i,
   output logic cmp_o
);
   import sadc_pkg::*;
   logic junk_r;
   // Unpowered or unknown input gives a pattern that changes every cycle
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         junk_r <= 1'b0;
      else
         junk_r <= ~junk_r;
   end
   // Level 3FF is full scale, 000 is bottom, linear between
   always_comb
   begin
      if (ana_i.pwr && ana_i.chan < 5'h08)
         cmp_o = (lvl_i[ana_i.chan[2:0]] >= ana_i.code);
      else
         cmp_o = junk_r;
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sadc_pkg::*;
   logic clk_i;
   logic rst_i = 1'b1;
   logic [4:0] avs_address_i = 5'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h00000000;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [2:0] fdiv = 3'h0;
   logic [7:0] port_pin_i = 8'h00;
   logic stop_i = 1'b0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o, cmp_i, irq_o;
   logic [7:0] port_pin_o, port_pin_oe_o;
   sadc_ana_t ana_o;
   logic [7:0][9:0] lvl = '0;
   int mismatches = 0;
   int tests_run = 0;
   int n;
   logic [7:0] rd, rh, rl, m;
   logic [2:0] ch;
   logic [1:0] fmt = 2'h0;
   logic [9:0] va, vb;
   logic [15:0] e;
   sadc_top sadc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .port_pin_i(port_pin_i), .port_pin_o(port_pin_o),
      .port_pin_oe_o(port_pin_oe_o), .cmp_i(cmp_i), .alt_tick_i(1'b0), .stop_i(stop_i),
      .ana_o(ana_o), .irq_o(irq_o));
   sadc_ana_model sadc_ana_model_inst (.clk_i(clk_i), .rst_i(rst_i), .ana_i(ana_o),
      .lvl_i(lvl), .cmp_o(cmp_i));
   // Clock and watchdog
   initial
   begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (100000) @(posedge clk_i);
      mismatches++;
      final_report();
   end
   task final_report;
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp)
         mismatches++;
   endtask
   // One bus access, held until waitrequest is sampled low
   task bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      int k;
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= {24'h000000, d};
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (avs_waitrequest_o !== 1'b0 && k < 20);
      q = avs_readdata_o[7:0];
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (k >= 20)
      begin
         mismatches++;
         final_report();
      end
   endtask
   task wait_flag;
      int k;
      k = 0;
      do
      begin
         bus(1'b0, A_SCR, 8'h00, rd);
         k++;
      end
      while (rd[SCR_FLAG] !== 1'b1 && k < 80);
      chk({7'h00, rd[SCR_FLAG]}, 8'h01);
      if (k >= 80)
         final_report();
   endtask
   task wait_irq;
      n = 0;
      while (irq_o !== 1'b1 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask
   // Expected high and low result bytes per format
   function logic [15:0] fexp(input logic [1:0] f, input logic [9:0] c);
      case (f)
         2'h0: fexp = {8'h00, c[9:2]};
         2'h1: fexp = {6'h00, c[9:8], c[7:0]};
         2'h2: fexp = {c[9:2], c[1:0], 6'h00};
         default: fexp = {~c[9], c[8:2], c[1:0], 6'h00};
      endcase
   endfunction
   task set_fmt(input logic [1:0] f);
      fmt = f;
      bus(1'b1, A_CLK, {fdiv, 1'b0, f, 2'b00}, rd);
   endtask
   task rd_res(input logic [9:0] v);
      e = fexp(fmt, v);
      bus(1'b0, A_RH, 8'h00, rh);
      bus(1'b0, A_RL, 8'h00, rl);
      chk(rh, e[15:8]);
      chk(rl, e[7:0]);
   endtask
   task conv(input logic [2:0] c, input logic [9:0] v);
      lvl[c] <= v;
      bus(1'b1, A_SCR, {5'h00, c}, rd);
      wait_flag();
      chk(rd, {3'b100, 2'b00, c});
      rd_res(v);
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd[7:0], {5'h00, c});
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   initial
   begin
      void'($urandom(59));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd, {3'b000, CH_OFF});
      bus(1'b0, A_CLK, 8'h00, rd);
      chk(rd, CLK_RST);
      // Write with the low byte disabled must be ignored
      avs_byteenable_i <= 4'h0;
      bus(1'b1, A_CLK, 8'hFF, rd);
      avs_byteenable_i <= 4'hF;
      bus(1'b0, A_CLK, 8'h00, rd);
      chk(rd, CLK_RST);
      bus(1'b0, 5'h18, 8'h00, rd);
      chk(rd, 8'h00);
      done("reset");
      ch = 3'($urandom_range(7));
      m = 8'hFF & ~(8'h01 << ch);
      bus(1'b1, A_SCR, {5'h00, ch}, rd);
      bus(1'b1, A_PDIR, 8'hFF, rd);
      bus(1'b1, A_PDAT, 8'hFF, rd);
      repeat (2) @(posedge clk_i);
      chk(port_pin_o, m);
      chk(port_pin_oe_o, m);
      bus(1'b0, A_PDAT, 8'h00, rd);
      chk(rd, m);
      wait_flag();
      rd_res(lvl[ch]);
      done("port");
      for (int i = 0; i < 8; i++)
      begin
         fdiv = 3'(i % 4);
         set_fmt(2'(i % 4));
         port_pin_i <= 8'($urandom);
         va = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
         conv(3'(i), va);
      end
      repeat (60) @(posedge clk_i);
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd, 8'h07);
      done("formats");
      fdiv = 3'h0;
      set_fmt(2'h2);
      va = 10'($urandom);
      vb = ~va;
      lvl[2] <= va;
      bus(1'b1, A_SCR, 8'h02, rd);
      wait_flag();
      bus(1'b0, A_RH, 8'h00, rh);
      lvl[2] <= vb;
      bus(1'b1, A_SCR, 8'h02, rd);
      repeat (60) @(posedge clk_i);
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd, 8'h02);
      bus(1'b0, A_RL, 8'h00, rl);
      chk(rl, {va[1:0], 6'h00});
      set_fmt(2'h0);
      conv(3'h2, va);
      bus(1'b0, A_RH, 8'h00, rh);
      lvl[2] <= vb;
      bus(1'b1, A_SCR, 8'h02, rd);
      wait_flag();
      bus(1'b0, A_RL, 8'h00, rl);
      chk(rl, vb[9:2]);
      done("interlock");
      set_fmt(2'h1);
      lvl[5] <= va;
      bus(1'b1, A_SCR, 8'h25, rd);
      wait_flag();
      lvl[5] <= vb;
      repeat (60) @(posedge clk_i);
      rd_res(vb);
      bus(1'b1, A_SCR, 8'h05, rd);
      wait_flag();
      rd_res(vb);
      done("continuous");
      bus(1'b1, A_SCR, 8'h45, rd);
      wait_irq();
      chk(8'((n >= 17 && n <= 19)), 8'h01);
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd, 8'h45);
      bus(1'b0, A_RL, 8'h00, rl);
      @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00);
      bus(1'b1, A_SCR, 8'h45, rd);
      wait_irq();
      chk(8'((n >= 17 && n <= 19)), 8'h01);
      // Restart after the result is done; the control write clears irq
      bus(1'b1, A_SCR, 8'h45, rd);
      @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00);
      done("interrupt");
      // Power down before idling, as when the converter cannot wake the core
      bus(1'b1, A_SCR, {3'b000, CH_OFF}, rd);
      repeat (2) @(posedge clk_i);
      chk({7'h00, ana_o.pwr}, 8'h00);
      lvl[6] <= va;
      bus(1'b1, A_SCR, 8'h06, rd);
      repeat (20) @(posedge clk_i);
      stop_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk({7'h00, ana_o.pwr}, 8'h00);
      repeat (80) @(posedge clk_i);
      bus(1'b0, A_SCR, 8'h00, rd);
      chk(rd, 8'h06);
      stop_i <= 1'b0;
      wait_flag();
      rd_res(va);
      done("stop");
      final_report();
   end
endmodule
`default_nettype wire
